// ==== ssp_regs.svh ====
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

`define SSP_ADDR_RX_CTRL 12'h000
`define SSP_ADDR_RX_BUF 12'h004
`define SSP_ADDR_TX_CTRL 12'h008
`define SSP_ADDR_BAUD_CTRL 12'h00C
`define SSP_ADDR_DIV_HI 12'h010
`define SSP_ADDR_DIV_LO 12'h014
`define SSP_ADDR_TX_BUF 12'h018
`define SSP_ADDR_IRQ 12'h01C

// receive_status_control fields
`define SSP_RC_PORT_EN 7
`define SSP_RC_RX9 6
`define SSP_RC_SINGLE_RECEIVE_ENABLE 5
`define SSP_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define SSP_RC_FRAMING_ERROR 2
`define SSP_RC_OVERRUN_ERROR 1
`define SSP_RC_RX9D 0
// transmit_status_control fields
`define SSP_TC_MASTER 7
`define SSP_TC_TX9 6
`define SSP_TC_TRANSMIT_ENABLE 5
`define SSP_TC_SYNC 4
`define SSP_TC_TRMT 1
`define SSP_TC_TX_NINTH_VALUE 0
// baud_control fields
`define SSP_BC_CKP 4
`define SSP_BC_WIDE 3
// irq register fields
`define SSP_IRQ_RXIE 3
`define SSP_IRQ_TX_IRQ_ENABLE 2
`define SSP_IRQ_RXF 1
`define SSP_IRQ_TXF 0

`define SSP_RST_RX_CTRL 8'h00
`define SSP_RST_TX_CTRL 8'h02
`define SSP_RST_BAUD 8'h00
`define SSP_RST_DIV 8'h00

`endif

// ==== ssp_pkg.sv ====
package ssp_pkg;
    typedef enum logic [1:0] {
        SSP_RX_IDLE,
        SSP_RX_SHIFT
    } ssp_rx_state_t;
endpackage

// ==== ssp_sync_port.sv ====
// Our own choices: the APB register port and the register addresses.
`include "ssp_regs.svh"

// Contract
// - reception starts when single or continuous receive enable is set (code: master mode only; slave mode never receives)
// - master reception samples data at falling shift clock edge
// - single receive takes exactly one word then stops
// - continuous receive runs back to back until enable cleared
// - both enables set behaves as continuous reception
// - clearing continuous enable clears receive error state
// - shift rate from 16-bit divisor; wide select picks divisor width
// - polarity invert bit inverts the clock pin
// - ninth-bit enable receives nine bits, ninth into status register
// - reception done sets flag; interrupt if receive irq enabled
// - received data presented as 8-bit word in receive buffer
// - master select clear gives slave mode on external clock
// - slave mode shifts in low-power mode on external clock
// - slave transmit acts as master transmit apart from sleep
// - two words before sleep: first shifts, second buffered, flag clear
// - after first word shifts, second moves in then flag set
// - buffer-free event wakes device when transmit irq enabled
// - slave transmission begins on write of transmit buffer
module ssp_sync_port
    import ssp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_mode,
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe_n,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe_n,
    output logic irq,
    output logic wake
);
    logic [7:0] rx_ctrl_r, tx_ctrl_r, baud_r, div_hi_r, div_lo_r;
    logic [7:0] rx_buf_r, tx_buf_r;
    logic tx_buf_full_r, rx_done_r, rx_ie_r, tx_ie_r;
    logic [8:0] rx_sh_r, tx_sh_r;
    logic [3:0] rx_cnt_r, tx_cnt_r;
    logic tx_busy_r, sck_r, data_out_r;
    logic [15:0] div_cnt_r;
    logic [1:0] ck_sync_r, dt_sync_r;
    logic ck_prev_r;
    ssp_rx_state_t rx_st_r;

    logic wr, rd, master, active, sck_fall, sck_rise, ext_fall, ext_rise;
    logic shift_fall, shift_rise, rx_finish, tx_load, tx_finish;
    logic [15:0] div_val;
    logic [3:0] rx_len, tx_len;
    logic ck_s, dt_s;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign master = rx_ctrl_r[`SSP_RC_PORT_EN] && tx_ctrl_r[`SSP_TC_SYNC]
        && tx_ctrl_r[`SSP_TC_MASTER];
    assign active = rx_ctrl_r[`SSP_RC_PORT_EN] && tx_ctrl_r[`SSP_TC_SYNC];
    assign ck_s = ck_sync_r[1];
    assign dt_s = dt_sync_r[1];

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_sync_r <= 2'h0;
            dt_sync_r <= 2'h0;
            ck_prev_r <= 1'b0;
        end else begin
            ck_sync_r <= {ck_sync_r[0], clk_pin_in};
            dt_sync_r <= {dt_sync_r[0], data_pin_in};
            ck_prev_r <= ck_s;
        end
    end
    // external clock seen through the polarity bit
    assign ext_fall = (ck_prev_r ^ baud_r[`SSP_BC_CKP])
        && !(ck_s ^ baud_r[`SSP_BC_CKP]);
    assign ext_rise = !(ck_prev_r ^ baud_r[`SSP_BC_CKP])
        && (ck_s ^ baud_r[`SSP_BC_CKP]);

    // divisor width selected by the wide bit
    assign div_val = baud_r[`SSP_BC_WIDE] ? {div_hi_r, div_lo_r}
        : {8'h00, div_lo_r};
    logic run_clk;
    assign run_clk = master && (rx_st_r == SSP_RX_SHIFT || tx_busy_r);

    // master shift clock, half period = divisor+1 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 16'h0000;
            sck_r <= 1'b0;
        end else if (!run_clk) begin
            div_cnt_r <= 16'h0000;
            sck_r <= 1'b0;
        end else if (div_cnt_r >= div_val) begin
            div_cnt_r <= 16'h0000;
            sck_r <= !sck_r;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end
    assign sck_fall = run_clk && sck_r && div_cnt_r >= div_val;
    assign sck_rise = run_clk && !sck_r && div_cnt_r >= div_val;
    // slave mode shifts only on the external clock, so sleep is irrelevant
    assign shift_fall = master ? sck_fall : ext_fall;
    assign shift_rise = master ? sck_rise : ext_rise;

    assign clk_pin_out = sck_r ^ baud_r[`SSP_BC_CKP];
    assign clk_pin_oe_n = !master;

    // receive engine
    assign rx_len = rx_ctrl_r[`SSP_RC_RX9] ? 4'h9 : 4'h8;
    assign rx_finish = rx_st_r == SSP_RX_SHIFT && shift_fall
        && rx_cnt_r == rx_len - 4'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_r <= SSP_RX_IDLE;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else begin
            unique case (rx_st_r)
                SSP_RX_IDLE: begin
                    rx_cnt_r <= 4'h0;
                    if (active && master && (rx_ctrl_r[`SSP_RC_SINGLE_RECEIVE_ENABLE]
                        || rx_ctrl_r[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]))
                        rx_st_r <= SSP_RX_SHIFT;
                end
                SSP_RX_SHIFT: begin
                    if (!(rx_ctrl_r[`SSP_RC_SINGLE_RECEIVE_ENABLE] || rx_ctrl_r[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE])
                        || !active) begin
                        rx_st_r <= SSP_RX_IDLE;
                    end else if (shift_fall) begin
                        // lsb first, sampled at falling edge
                        rx_sh_r <= {dt_s, rx_sh_r[8:1]};
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_finish) begin
                            rx_cnt_r <= 4'h0;
                            // continuous wins over single
                            if (!rx_ctrl_r[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE])
                                rx_st_r <= SSP_RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end
    logic [8:0] rx_word;
    assign rx_word = rx_ctrl_r[`SSP_RC_RX9] ? {dt_s, rx_sh_r[8:1]}
        : {1'b0, dt_s, rx_sh_r[8:2]};

    // receive status/control and buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctrl_r <= `SSP_RST_RX_CTRL;
            rx_buf_r <= 8'h00;
        end else begin
            if (wr && paddr == `SSP_ADDR_RX_CTRL)
                rx_ctrl_r[7:4] <= pwdata[7:4];
            if (rx_finish) begin
                rx_buf_r <= rx_word[7:0];
                rx_ctrl_r[`SSP_RC_RX9D] <= rx_word[8];
                if (rx_done_r && !(rd && paddr == `SSP_ADDR_RX_BUF))
                    rx_ctrl_r[`SSP_RC_OVERRUN_ERROR] <= 1'b1;
                if (!rx_ctrl_r[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE])
                    rx_ctrl_r[`SSP_RC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            end
            // error state follows continuous enable
            if (!rx_ctrl_r[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] && !rx_finish) begin
                rx_ctrl_r[`SSP_RC_OVERRUN_ERROR] <= 1'b0;
                rx_ctrl_r[`SSP_RC_FRAMING_ERROR] <= 1'b0;
            end
        end
    end

    // done flag: set wins over clear by buffer read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rx_done_r <= 1'b0;
        else if (rx_finish)
            rx_done_r <= 1'b1;
        else if (rd && paddr == `SSP_ADDR_RX_BUF)
            rx_done_r <= 1'b0;
    end

    // transmit buffer and shifter
    assign tx_len = tx_ctrl_r[`SSP_TC_TX9] ? 4'h9 : 4'h8;
    assign tx_finish = tx_busy_r && shift_fall && tx_cnt_r == tx_len - 4'h1;
    assign tx_load = tx_buf_full_r && tx_ctrl_r[`SSP_TC_TRANSMIT_ENABLE] && active
        && (!tx_busy_r || tx_finish);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ctrl_r <= `SSP_RST_TX_CTRL;
            tx_buf_r <= 8'h00;
            tx_buf_full_r <= 1'b0;
        end else begin
            if (wr && paddr == `SSP_ADDR_TX_CTRL) begin
                tx_ctrl_r[7:4] <= pwdata[7:4];
                tx_ctrl_r[`SSP_TC_TX_NINTH_VALUE] <= pwdata[0];
            end
            tx_ctrl_r[`SSP_TC_TRMT] <= !tx_busy_r && !tx_load;
            if (wr && paddr == `SSP_ADDR_TX_BUF) begin
                tx_buf_r <= pwdata[7:0];
                tx_buf_full_r <= 1'b1;
            end else if (tx_load) begin
                tx_buf_full_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= 9'h000;
            tx_cnt_r <= 4'h0;
            data_out_r <= 1'b0;
        end else if (tx_load) begin
            // same path in both modes; only the clock source differs
            tx_busy_r <= 1'b1;
            tx_sh_r <= {tx_ctrl_r[`SSP_TC_TX_NINTH_VALUE], tx_buf_r};
            tx_cnt_r <= 4'h0;
            data_out_r <= tx_buf_r[0];
        end else if (tx_finish || !tx_ctrl_r[`SSP_TC_TRANSMIT_ENABLE] || !active) begin
            tx_busy_r <= 1'b0;
        end else if (tx_busy_r && shift_fall) begin
            tx_sh_r <= {1'b0, tx_sh_r[8:1]};
            tx_cnt_r <= tx_cnt_r + 4'h1;
            data_out_r <= tx_sh_r[1];
        end
    end
    assign data_pin_out = data_out_r;
    assign data_pin_oe_n = !(tx_busy_r && tx_ctrl_r[`SSP_TC_TRANSMIT_ENABLE]);

    // irq enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ie_r <= 1'b0;
            tx_ie_r <= 1'b0;
        end else if (wr && paddr == `SSP_ADDR_IRQ) begin
            rx_ie_r <= pwdata[`SSP_IRQ_RXIE];
            tx_ie_r <= pwdata[`SSP_IRQ_TX_IRQ_ENABLE];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_r <= `SSP_RST_BAUD;
            div_hi_r <= `SSP_RST_DIV;
            div_lo_r <= `SSP_RST_DIV;
        end else if (wr) begin
            if (paddr == `SSP_ADDR_BAUD_CTRL)
                baud_r <= {3'h0, pwdata[4:3], 3'h0};
            if (paddr == `SSP_ADDR_DIV_HI)
                div_hi_r <= pwdata[7:0];
            if (paddr == `SSP_ADDR_DIV_LO)
                div_lo_r <= pwdata[7:0];
        end
    end

    logic tx_free;
    // buffer-free only after the buffered word has moved to the shifter
    assign tx_free = !tx_buf_full_r;
    assign irq = (rx_done_r && rx_ie_r) || (tx_free && tx_ie_r);
    assign wake = sleep_mode && tx_free && tx_ie_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `SSP_ADDR_RX_CTRL: prdata <= {24'h0, rx_ctrl_r};
                `SSP_ADDR_RX_BUF: prdata <= {24'h0, rx_buf_r};
                `SSP_ADDR_TX_CTRL: prdata <= {24'h0, tx_ctrl_r};
                `SSP_ADDR_BAUD_CTRL: prdata <= {24'h0, baud_r};
                `SSP_ADDR_DIV_HI: prdata <= {24'h0, div_hi_r};
                `SSP_ADDR_DIV_LO: prdata <= {24'h0, div_lo_r};
                `SSP_ADDR_IRQ: prdata <= {28'h0, rx_ie_r, tx_ie_r,
                    rx_done_r, tx_free};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ==== ssp_chk_assertions.sv ====
`include "ssp_regs.svh"

module ssp_chk
    import ssp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_mode,
    input wire logic irq,
    input wire logic wake
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // read data is latched in setup, so the access cycle already shows it
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence
    sequence s_irq_wr;
        psel && penable && pwrite && paddr == `SSP_ADDR_IRQ;
    endsequence

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_no_error: assert property (!pslverr)
        else $error("pslverr raised");
    a_unmapped_zero: assert property (
        s_rd_setup ##0 (paddr > `SSP_ADDR_IRQ) |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_wake_sleep: assert property (wake |-> sleep_mode)
        else $error("wake outside sleep");
    a_wake_irq: assert property (wake |-> irq)
        else $error("wake without irq");
    a_irq_masked: assert property (
        s_irq_wr ##0 pwdata[3:2] == 2'b00 |=> !irq [*2])
        else $error("irq with enables clear");
    a_wake_masked: assert property (
        s_irq_wr ##0 !pwdata[2] |=> !wake)
        else $error("wake with tx enable clear");
endmodule

bind ssp_sync_port ssp_chk ssp_chk_i (.*);

// ==== ssp_peer.sv ====
module ssp_peer (
    input wire logic clk_pin_out,
    input wire logic data_pin_out,
    input wire logic [8:0] word,
    input wire logic [3:0] nb,
    output logic data_pin_in,
    output logic clk_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last = 1'b0;
    logic [7:0] got;
    int falls = 0;
    int words = 0;
    int cnt = 0;

    initial begin
        data_pin_in = 1'b0;
        clk_pin_in = 1'b0;
    end

    // only clean swings count: the pin is unknown until reset lands
    always @(clk_pin_out) begin
        if (last === 1'b1 && clk_pin_out === 1'b0) begin
            falls++;
            words += int'(cnt == nb - 1);
            cnt = (cnt == nb - 1) ? 0 : cnt + 1;
        end else if (last === 1'b0 && clk_pin_out === 1'b1)
            data_pin_in <= word[cnt];
        last = clk_pin_out;
    end

    // clock idles low and runs only inside a frame; the device moves its
    // data on the falling edge, so the rising edge finds it settled
    task automatic clocks(input int n);
        #13;
        repeat (n) begin
            #40 clk_pin_in = 1'b1;
            got = {data_pin_out, got[7:1]};
            #40 clk_pin_in = 1'b0;
        end
    endtask
endmodule

// ==== sync_serial_port_rx_tx_test.sv ====
`include "ssp_regs.svh"

module sync_serial_port_rx_tx_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sleep_mode = 1'b0;
    logic clk_pin_in, data_pin_in, clk_pin_out, clk_pin_oe_n;
    logic data_pin_out, data_pin_oe_n, irq, wake, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h4515A1D6;
    logic [8:0] word = 9'h000;
    logic [7:0] w1, w2;
    logic [3:0] nb = 4'h8;
    int fail_count = 0, compares = 0, i, n0;

    ssp_sync_port ssp_sync_port_i (.*);
    ssp_peer ssp_peer_i (.*);

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic print_verdict();
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic timeout();
        fail_count++;
        print_verdict();
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (k >= 64)
            timeout();
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_flag(input int b);
        for (int k = 0; k < 300; k++) begin
            apb(0, `SSP_ADDR_IRQ, 0);
            if (r[b] === 1'b1)
                return;
        end
        timeout();
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `SSP_ADDR_RX_CTRL, 0);
        chk("rx_ctrl", 32'h00, r);
        apb(0, `SSP_ADDR_TX_CTRL, 0);
        chk("tx_ctrl", 32'h02, r);
        chk("irq", 0, 32'(irq));
        chk("data_oe_n", 1, 32'(data_pin_oe_n));
        apb(0, 12'h020, 0);
        chk("unmapped", 32'h00, r);
        apb(1, `SSP_ADDR_TX_CTRL, 32'h90);
        apb(1, `SSP_ADDR_DIV_HI, 0);
        apb(1, `SSP_ADDR_BAUD_CTRL, 32'h08);
        apb(0, `SSP_ADDR_BAUD_CTRL, 0);
        chk("baud", 32'h08, r);
        apb(1, `SSP_ADDR_DIV_LO, 3 + rnd() % 4);
        apb(1, `SSP_ADDR_IRQ, 32'h08);
        for (i = 0; i < 2; i++) begin
            word = 9'(rnd());
            nb = 4'(8 + i);
            apb(1, `SSP_ADDR_RX_CTRL, 32'h80 | i << 6);
            apb(1, `SSP_ADDR_RX_CTRL, 32'hA0 | i << 6);
            wait_flag(1);
            chk("irq", 1, 32'(irq));
            apb(0, `SSP_ADDR_RX_CTRL, 0);
            chk("rx_ctrl", 32'h80 | i << 6 | (word[8] & i[0]), r);
            apb(0, `SSP_ADDR_RX_BUF, 0);
            chk("rx_buf", 32'(word[7:0]), r);
            chk("irq", 0, 32'(irq));
            n0 = ssp_peer_i.falls;
            repeat (60) @(posedge pclk);
            chk("falls", n0, ssp_peer_i.falls);
        end
        nb = 4'h8;
        apb(1, `SSP_ADDR_RX_CTRL, 32'h80);
        n0 = ssp_peer_i.words;
        apb(1, `SSP_ADDR_RX_CTRL, 32'hB0);
        for (i = 0; i < 4000 && ssp_peer_i.words < n0 + 2; i++)
            @(posedge pclk);
        if (i == 4000)
            timeout();
        repeat (8) @(posedge pclk);
        apb(0, `SSP_ADDR_RX_CTRL, 0);
        chk("rx_ctrl", 32'hB2, r);
        apb(1, `SSP_ADDR_RX_CTRL, 32'h80);
        apb(0, `SSP_ADDR_RX_CTRL, 0);
        chk("rx_ctrl", 32'h80, r);
        apb(0, `SSP_ADDR_RX_BUF, 0);
        repeat (20) @(posedge pclk);
        chk("clk_pin", 0, 32'(clk_pin_out));
        apb(1, `SSP_ADDR_BAUD_CTRL, 32'h10);
        chk("clk_pin", 1, 32'(clk_pin_out));
        apb(1, `SSP_ADDR_BAUD_CTRL, 0);
        apb(1, `SSP_ADDR_TX_CTRL, 32'h30);
        chk("clk_oe_n", 1, 32'(clk_pin_oe_n));
        apb(1, `SSP_ADDR_IRQ, 32'h04);
        sleep_mode <= 1'b1;
        w1 = 8'(rnd());
        w2 = 8'(rnd());
        apb(1, `SSP_ADDR_TX_BUF, w1);
        apb(1, `SSP_ADDR_TX_BUF, w2);
        apb(0, `SSP_ADDR_IRQ, 0);
        chk("tx_free", 0, 32'(r[0]));
        chk("wake", 0, 32'(wake));
        chk("data_oe_n", 0, 32'(data_pin_oe_n));
        ssp_peer_i.clocks(8);
        @(posedge pclk);
        for (i = 0; i < 50 && wake !== 1'b1; i++)
            @(posedge pclk);
        chk("wake", 1, 32'(wake));
        chk("tx_word", 32'(w1), 32'(ssp_peer_i.got));
        apb(0, `SSP_ADDR_IRQ, 0);
        chk("tx_free", 1, 32'(r[0]));
        ssp_peer_i.clocks(8);
        @(posedge pclk);
        chk("tx_word", 32'(w2), 32'(ssp_peer_i.got));
        apb(1, `SSP_ADDR_IRQ, 0);
        chk("irq", 0, 32'(irq));
        chk("data_oe_n", 1, 32'(data_pin_oe_n));
        print_verdict();
    end
endmodule
